// *** src/acc_top.sv ***
// conversion control: channel select, start, flags, readout
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
module acc_top
    import acc_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // register port
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [DATA_W-1:0]   reg_rdata,
    // converter module
    output logic                     conv_start,
    input  wire logic                busy_monitor_input,
    input  wire logic [RES_W-1:0]    conv_result,
    // multiplexers
    output logic      [EXT_CH_W-1:0] ext_mux_chan,
    output logic      [MUX8_W-1:0]   onboard_mux_sel,
    // trigger
    input  wire logic                external_trigger_input,
    // interrupts
    output logic                     conversion_done_irq,
    output logic                     trigger_event_irq,
    output logic                     irq
);
    logic                busy_lvl;
    logic                busy_fall;
    logic                trig_rise;
    logic                trig_fall;
    logic                trig_edge;
    logic                std_start;
    logic                sync_start;
    logic                rd_hi;
    logic                rd_lo;
    logic [RES_W-1:0]    res_meta_q;
    logic [RES_W-1:0]    res_sync_q;
    logic                mode_q;
    logic                trig_rise_q;
    logic                trig_ie_q;
    logic                done_ie_q;
    logic                done_flag_q;
    logic                done_flag_d;
    logic                trig_flag_q;
    logic                trig_flag_d;
    logic [1:0]          irq_stat_q;
    logic [1:0]          irq_mask_q;
    logic [1:0]          irq_ev;
    logic [DATA_W-1:0]   data_hi_q;
    logic [DATA_W-1:0]   data_lo_q;
    logic [DATA_W-1:0]   rdata_q;
    logic                start_q;
    logic [EXT_CH_W-1:0] ext_chan_q;
    logic [MUX8_W-1:0]   mux8_q;
    logic                done_irq_q;
    logic                trig_irq_q;
    logic                irq_q;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // busy line from the converter module
    acc_edge u_busy
    (
        .clk    (clk),
        .rst_n  (rst_n),
        .sig_in (busy_monitor_input),
        .level  (busy_lvl),
        .rise   (),
        .fall   (busy_fall)
    );

    acc_edge u_trig
    (
        .clk    (clk),
        .rst_n  (rst_n),
        .sig_in (external_trigger_input),
        .level  (),
        .rise   (trig_rise),
        .fall   (trig_fall)
    );

    // result bus is stable once busy drops; two stages keep it aligned
    // with the synchronised busy edge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            res_meta_q <= '0;
            res_sync_q <= '0;
        end
        else
        begin
            res_meta_q <= conv_result;
            res_sync_q <= res_meta_q;
        end
    end

    // (R5) edge selected by control word
    assign trig_edge  = trig_rise_q ? trig_rise : trig_fall;
    assign std_start  = reg_wr & hit(reg_addr, OFS_STROBE) & ~mode_q;
    // (R3) trigger alone starts in synchronous mode
    assign sync_start = mode_q & trig_edge;
    assign rd_hi      = reg_rd & hit(reg_addr, OFS_DATA_HI);
    assign rd_lo      = reg_rd & hit(reg_addr, OFS_DATA_LO);

    // configuration written by software
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mode_q      <= 1'b0;
            trig_rise_q <= 1'b0;
            // (R17) enables off after reset
            trig_ie_q   <= 1'b0;
            done_ie_q   <= 1'b0;
            mux8_q      <= '0;
            irq_mask_q  <= IRQ_RST;
        end
        else if (reg_wr)
        begin
            if (hit(reg_addr, OFS_MODE))
                mode_q <= reg_wdata[MODE_BIT];
            // (R5) edge and interrupt enable
            if (hit(reg_addr, OFS_TRIG_CW))
            begin
                trig_rise_q <= reg_wdata[CW_RISE_BIT];
                trig_ie_q   <= reg_wdata[CW_IE_BIT];
            end
            // (R9) falling edge fixed, bit 0 enables
            if (hit(reg_addr, OFS_DONE_CW))
                done_ie_q <= reg_wdata[CW_IE_BIT];
            // (R2) on-board input select
            if (hit(reg_addr, OFS_MUX8))
                mux8_q <= reg_wdata[MUX8_W-1:0];
            if (hit(reg_addr, OFS_IRQ_MSK))
                irq_mask_q <= reg_wdata[1:0];
        end
    end

    // channel latch and start pulse
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ext_chan_q <= '0;
            start_q    <= 1'b0;
        end
        else
        begin
            // (R1) strobe byte sets external channel
            if (reg_wr && hit(reg_addr, OFS_STROBE))
                ext_chan_q <= reg_wdata[EXT_CH_W-1:0];
            // (R16) start on strobe or trigger
            start_q <= std_start | sync_start;
        end
    end

    // result capture at completion
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            data_hi_q <= BYTE_RST;
            data_lo_q <= BYTE_RST;
        end
        else if (busy_fall)
        begin
            // (R15) high byte on trigger-side data channel
            data_hi_q <= res_sync_q[RES_W-1:4];
            // low nibble of the low byte carries nothing
            data_lo_q <= {res_sync_q[3:0], 4'h0};
        end
    end

    // section flags: a new event beats a clearing read
    always_comb
    begin
        done_flag_d = done_flag_q;
        trig_flag_d = trig_flag_q;
        // (R11) data read clears section flag
        if (rd_lo)
            done_flag_d = 1'b0;
        if (rd_hi)
            trig_flag_d = 1'b0;
        // (R10) completion sets bit 7
        if (busy_fall)
            done_flag_d = 1'b1;
        // (R6) set regardless of enable
        if (trig_edge)
            trig_flag_d = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            // (R17) flags and lines clear
            done_flag_q <= 1'b0;
            trig_flag_q <= 1'b0;
            done_irq_q  <= 1'b0;
            trig_irq_q  <= 1'b0;
        end
        else
        begin
            done_flag_q <= done_flag_d;
            trig_flag_q <= trig_flag_d;
            // (R8) busy fall drives done request
            done_irq_q  <= done_flag_d & done_ie_q;
            trig_irq_q  <= trig_flag_d & trig_ie_q;
        end
    end

    // sticky event register, write one to clear, set wins
    assign irq_ev = {trig_edge, busy_fall};

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_stat_q <= IRQ_RST;
            irq_q      <= 1'b0;
        end
        else
        begin
            if (reg_wr && hit(reg_addr, OFS_IRQ_ST))
                irq_stat_q <= (irq_stat_q & ~reg_wdata[1:0]) | irq_ev;
            else
                irq_stat_q <= irq_stat_q | irq_ev;
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // read data stands one cycle, zero otherwise
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata_q <= BYTE_RST;
        else if (!reg_rd)
            rdata_q <= BYTE_RST;
        else
        begin
            case (reg_addr)
                OFS_STROBE:  rdata_q <= {1'b0, ext_chan_q};
                OFS_MUX8:    rdata_q <= {5'h00, mux8_q};
                // (R7) busy level visible beside the flag
                OFS_DONE_CW: rdata_q <= {done_flag_q, 5'h00,
                                         busy_lvl, done_ie_q};
                OFS_DATA_HI: rdata_q <= data_hi_q;
                OFS_TRIG_CW: rdata_q <= {trig_flag_q, 5'h00,
                                         trig_rise_q, trig_ie_q};
                OFS_DATA_LO: rdata_q <= data_lo_q;
                OFS_IRQ_ST:  rdata_q <= {6'h00, irq_stat_q};
                OFS_IRQ_MSK: rdata_q <= {6'h00, irq_mask_q};
                OFS_MODE:    rdata_q <= {7'h00, mode_q};
                default:     rdata_q <= BYTE_RST;
            endcase
        end
    end

    assign reg_rdata           = rdata_q;
    assign conv_start          = start_q;
    assign ext_mux_chan        = ext_chan_q;
    assign onboard_mux_sel     = mux8_q;
    assign conversion_done_irq = done_irq_q;
    assign trigger_event_irq   = trig_irq_q;
    assign irq                 = irq_q;

    chk_strobe_start: assert property ( // R1
        @(posedge clk) disable iff (!rst_n)
        std_start |=> conv_start && ext_mux_chan == $past(reg_wdata[6:0]))
        else $error("strobe write did not start conversion");

    chk_mux8_select: assert property ( // R2
        @(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == OFS_MUX8
        |=> onboard_mux_sel == $past(reg_wdata[2:0]))
        else $error("on-board select not taken");

    chk_sync_no_strobe: assert property ( // R3
        @(posedge clk) disable iff (!rst_n)
        mode_q && !trig_edge |=> !conv_start)
        else $error("start without trigger in synchronous mode");

    chk_trig_flag_set: assert property ( // R6
        @(posedge clk) disable iff (!rst_n)
        trig_edge |=> trig_flag_q)
        else $error("trigger edge did not set flag");

    chk_done_irq_edge: assert property ( // R8
        @(posedge clk) disable iff (!rst_n)
        busy_fall && done_ie_q && !(reg_wr && reg_addr == OFS_DONE_CW)
        |=> conversion_done_irq)
        else $error("done request missing after busy fall");

    chk_done_flag_set: assert property ( // R10
        @(posedge clk) disable iff (!rst_n)
        busy_fall |=> done_flag_q && data_hi_q == $past(res_sync_q[11:4]))
        else $error("completion did not set status bit");

    chk_read_clears: assert property ( // R11
        @(posedge clk) disable iff (!rst_n)
        rd_lo && !busy_fall |=> !done_flag_q && !conversion_done_irq)
        else $error("data read did not clear flag and request");

    chk_reset_quiet: assert property ( // R17
        @(posedge clk)
        !rst_n |=> !done_flag_q && !trig_flag_q && !conversion_done_irq
                   && !trigger_event_irq && !done_ie_q && !trig_ie_q)
        else $error("flags or enables set after reset");

    chk_irq_level: assert property ( // R8
        @(posedge clk) disable iff (!rst_n)
        |(irq_stat_q & irq_mask_q) |=> irq)
        else $error("interrupt output missing");

    chk_trig_irq_enable: assert property ( // R5
        @(posedge clk) disable iff (!rst_n)
        trig_edge && trig_ie_q && !(reg_wr && reg_addr == OFS_TRIG_CW)
        |=> trigger_event_irq)
        else $error("trigger request missing with enable set");

    chk_trig_read_clears: assert property ( // R11
        @(posedge clk) disable iff (!rst_n)
        rd_hi && !trig_edge |=> !trig_flag_q && !trigger_event_irq)
        else $error("high byte read did not clear trigger flag");

    chk_done_ie_off: assert property ( // R9
        @(posedge clk) disable iff (!rst_n)
        !done_ie_q |=> !conversion_done_irq)
        else $error("done request raised while disabled");

    chk_sync_start: assert property ( // R3
        @(posedge clk) disable iff (!rst_n)
        sync_start |=> conv_start)
        else $error("trigger did not start conversion");

    chk_busy_readback: assert property ( // R7
        @(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == OFS_DONE_CW
        |=> reg_rdata[1] == $past(busy_lvl))
        else $error("busy level not shown in status byte");
endmodule // acc_top

// *** pkg/acc_pkg.sv ***
// constants shared by the converter board control logic
// Summary of operation
// (R1) strobe write selects external channel, starts conversion
// (R2) selection byte picks on-board multiplexer input
// (R3) synchronous mode: one conversion per trigger
// (R4) host waits for flags before next start
// (R5) trigger control word sets edge, interrupt enable
// (R6) active trigger edge always sets trigger flag
// (R7) busy high during conversion, monitored
// (R8) busy falling edge raises done interrupt
// (R9) status control word enables done interrupt
// (R10) completion sets status bit 7
// (R11) data read clears flag and interrupt
// (R12) host drops low four result bits
// (R13) host waits conversion time before reading
// (R14) host leaves time between trigger bursts
// (R15) result high byte on trigger-side data channel
// (R16) strobe write starts conversion, sets channel
// (R17) reset clears flags, interrupts and enables
package acc_pkg;
    localparam int         ADDR_W      = 8;
    localparam int         DATA_W      = 8;
    localparam int         RES_W       = 12;
    localparam int         EXT_CH_W    = 7;
    localparam int         MUX8_W      = 3;
    // register offsets
    localparam logic [7:0] OFS_STROBE  = 8'h81;
    localparam logic [7:0] OFS_MUX8    = 8'h82;
    localparam logic [7:0] OFS_DONE_CW = 8'h84;
    localparam logic [7:0] OFS_DATA_HI = 8'h85;
    localparam logic [7:0] OFS_TRIG_CW = 8'h86;
    localparam logic [7:0] OFS_DATA_LO = 8'h87;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h88;
    localparam logic [7:0] OFS_IRQ_MSK = 8'h89;
    localparam logic [7:0] OFS_MODE    = 8'h8a;
    // field positions
    localparam int         CW_IE_BIT   = 0;
    localparam int         CW_RISE_BIT = 1;
    localparam int         FLAG_BIT    = 7;
    localparam int         MODE_BIT    = 0;
    localparam int         EV_DONE     = 0;
    localparam int         EV_TRIG     = 1;
    // reset values
    localparam logic [1:0] IRQ_RST     = 2'h0;
    localparam logic [7:0] BYTE_RST    = 8'h00;
endpackage

// *** src/acc_edge.sv ***
// two-stage synchroniser with rise and fall detection
`timescale 1ns/1ns
module acc_edge
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // asynchronous level in
    input  wire logic sig_in,
    // synchronised level and edges
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end
        else
        begin
            meta_q <= sig_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise  = sync_q & ~last_q;
    assign fall  = ~sync_q & last_q;
endmodule // acc_edge

// *** tb/acc_conv_model.sv ***
// stand-in for the converter module: busy period and result bus
`timescale 1ns/1ns
module acc_conv_model
    import acc_pkg::*;
#(
    parameter int               CONV_CYC = 20,
    parameter logic [RES_W-1:0] RES_BASE = 12'ha5c
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // start from the block
    input  wire logic             conv_start,
    // converter pins
    output logic                  busy,
    output logic      [RES_W-1:0] result
);
    int               cnt_q;
    logic [RES_W-1:0] val_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            busy   <= 1'b0;
            cnt_q  <= 0;
            val_q  <= RES_BASE;
            result <= ~RES_BASE;
        end
        else if (conv_start)
        begin
            busy  <= 1'b1;
            cnt_q <= CONV_CYC;
        end
        else if (busy)
        begin
            // bus churns while converting so a stale capture shows up
            result <= ~result;
            cnt_q  <= cnt_q - 1;
            if (cnt_q == 1)
            begin
                busy   <= 1'b0;
                result <= val_q;
                val_q  <= val_q + 12'h001;
            end
        end
    end
endmodule // acc_conv_model

// *** tb/acc_top_bench.sv ***
// self-checking bench for the conversion control block
`timescale 1ns/1ns
module acc_top_bench;
    import acc_pkg::*;
    localparam logic [11:0] RES0 = 12'ha5c;
    logic        clk;
    logic        rst_n;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        conv_start;
    logic        busy;
    logic [11:0] res;
    logic [6:0]  ext_mux_chan;
    logic [2:0]  onboard_mux_sel;
    logic        trig;
    logic        conversion_done_irq;
    logic        trigger_event_irq;
    logic        irq;
    logic [7:0]  d;
    logic [7:0]  cw;
    logic [11:0] exp_res;
    int          n_errors;
    int          check_count;
    int          n_starts = 0;
    int          s;
    logic [7:0]  cw_tab [4] = '{8'h06, 8'h07, 8'h04, 8'h05};

    acc_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .conv_start(conv_start),
        .busy_monitor_input(busy), .conv_result(res),
        .ext_mux_chan(ext_mux_chan), .onboard_mux_sel(onboard_mux_sel),
        .external_trigger_input(trig),
        .conversion_done_irq(conversion_done_irq),
        .trigger_event_irq(trigger_event_irq), .irq(irq));
    acc_conv_model #(.CONV_CYC(20), .RES_BASE(RES0)) conv (.clk(clk),
        .rst_n(rst_n), .conv_start(conv_start), .busy(busy), .result(res));

    always #2 clk = ~clk;
    always @(posedge clk)
        if (conv_start === 1'b1)
            n_starts <= n_starts + 1;

    task automatic chk(input string nm, input logic [11:0] seen,
                       input logic [11:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // host polls the flag before touching data, never a fixed delay
    task automatic wait_done();
        d = 8'h00;
        for (int i = 0; i < 60 && d[7] !== 1'b1; i++)
            rd(OFS_DONE_CW, d);
        chk("done flag", {11'h0, d[7]}, 12'h001);
    endtask

    task automatic readout();
        rd(OFS_DATA_HI, d);
        chk("data high", {4'h0, d}, {4'h0, exp_res[11:4]});
        rd(OFS_DATA_LO, d);
        chk("data low", {4'h0, d}, {4'h0, exp_res[3:0], 4'h0});
        exp_res = exp_res + 12'h001;
    endtask

    task automatic trig_to(input logic lv);
        @(posedge clk);
        trig <= lv;
        // room between triggers for the host
        repeat (8) @(posedge clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end

    initial
    begin
        clk = 0;
        rst_n = 0;
        reg_addr = 0;
        reg_wdata = 0;
        reg_wr = 0;
        reg_rd = 0;
        trig = 0;
        n_errors = 0;
        check_count = 0;
        exp_res = RES0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("irq lines", {9'h0, conversion_done_irq, trigger_event_irq, irq},
            12'h000);
        rd(OFS_DONE_CW, d);
        chk("done ctrl", {4'h0, d}, 12'h000);
        rd(OFS_TRIG_CW, d);
        chk("trig ctrl", {4'h0, d}, 12'h000);
        rd(OFS_IRQ_ST, d);
        chk("events", {4'h0, d}, 12'h000);
        rd(8'h90, d);
        chk("unmapped", {4'h0, d}, 12'h000);
        for (int k = 0; k < 8; k++)
        begin
            wr(OFS_MUX8, 8'(k));
            #1;
            chk("mux sel", {9'h0, onboard_mux_sel}, 12'(k));
        end
        wr(OFS_DONE_CW, 8'h05);
        wr(OFS_IRQ_MSK, 8'h03);
        wr(OFS_STROBE, 8'h60);
        #1;
        chk("start", {11'h0, conv_start}, 12'h001);
        chk("ext chan", {5'h0, ext_mux_chan}, 12'h060);
        wait_done();
        chk("done irq", {11'h0, conversion_done_irq}, 12'h001);
        chk("irq", {11'h0, irq}, 12'h001);
        rd(OFS_IRQ_ST, d);
        chk("events", {4'h0, d}, 12'h001);
        readout();
        repeat (2) @(posedge clk);
        #1;
        chk("done irq", {11'h0, conversion_done_irq}, 12'h000);
        rd(OFS_DONE_CW, d);
        chk("done flag", {11'h0, d[7]}, 12'h000);
        wr(OFS_IRQ_ST, 8'h01);
        wr(OFS_IRQ_MSK, 8'h00);
        #1;
        chk("irq", {11'h0, irq}, 12'h000);
        wr(OFS_DONE_CW, 8'h04);
        wr(OFS_STROBE, 8'h05);
        wait_done();
        chk("done irq", {11'h0, conversion_done_irq}, 12'h000);
        chk("irq masked", {11'h0, irq}, 12'h000);
        wr(OFS_IRQ_MSK, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        chk("irq unmasked", {11'h0, irq}, 12'h001);
        readout();
        wr(OFS_IRQ_ST, 8'h03);
        // rising codes, then falling; the second code of each pair sees the opposite edge first
        foreach (cw_tab[j])
        begin
            cw = cw_tab[j];
            wr(OFS_TRIG_CW, cw);
            trig_to(~cw[1]);
            rd(OFS_DATA_HI, d);
            rd(OFS_TRIG_CW, d);
            chk("trig flag", {11'h0, d[7]}, 12'h000);
            trig_to(cw[1]);
            rd(OFS_TRIG_CW, d);
            chk("trig flag", {11'h0, d[7]}, 12'h001);
            chk("trig irq", {11'h0, trigger_event_irq}, {11'h0, cw[0]});
            rd(OFS_DATA_HI, d);
            repeat (2) @(posedge clk);
            #1;
            chk("trig irq", {11'h0, trigger_event_irq}, 12'h000);
        end
        wr(OFS_IRQ_ST, 8'h03);
        wr(OFS_MODE, 8'h01);
        wr(OFS_TRIG_CW, 8'h06);
        s = n_starts;
        wr(OFS_STROBE, 8'h03);
        #1;
        chk("ext chan", {5'h0, ext_mux_chan}, 12'h003);
        for (int p = 0; p < 2; p++)
        begin
            trig_to(1'b1);
            trig_to(1'b0);
            wait_done();
            chk("starts", 12'(n_starts - s), 12'h001);
            readout();
            s = n_starts;
        end
        tally_and_finish();
    end
endmodule // acc_top_bench
